/* File: core/cdr_stage_regs.sv */
// per-stage routing and trim register bank with front-end decode
// assumes a classic Wishbone master on the same clock, and a sequencer that
// presents the active stage number on the same clock
`timescale 1ns/1ps

module cdr_stage_regs #(
    parameter int NUM_STAGES = cdr_pkg::NUM_STAGES
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [cdr_pkg::ADR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [cdr_pkg::DATA_W-1:0] i_wb_dat,
    output logic [cdr_pkg::DATA_W-1:0] o_wb_dat,
    output logic o_wb_ack,
    // sequencer
    input wire logic [cdr_pkg::STAGE_W-1:0] i_stage,
    // analog front end controls
    output cdr_pkg::cdr_frontend_type o_frontend
);

    // ==========================================
    // elaboration check
    if (NUM_STAGES < 1 || NUM_STAGES > 12) begin : g_bad_stages
        $error("NUM_STAGES must lie between 1 and 12");
    end

    // ==========================================
    // reset release
    logic rst_meta_b;   // first stage, read only by the second
    logic rst_sync_b;   // released reset for the whole block

    // release through two flops, assert at once
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // ==========================================
    // storage
    cdr_pkg::cdr_route_type route_reg [NUM_STAGES];
    cdr_pkg::cdr_trim_type trim_reg [NUM_STAGES];
    cdr_pkg::cdr_route_type next_route_reg [NUM_STAGES];
    cdr_pkg::cdr_trim_type next_trim_reg [NUM_STAGES];

    // ==========================================
    // bus decode
    logic [9:0] word_idx;      // word index of the access
    logic [9:0] rel_idx;       // index relative to the stage block
    logic [3:0] dec_stage;     // stage addressed
    logic in_stage_block;      // index lands in the stage block
    logic hit_route;           // routing register addressed
    logic hit_trim;            // trim register addressed
    logic hit_status;          // status register addressed
    logic req;                 // new request this cycle
    logic [15:0] wr_mask;      // byte lanes 0 and 1 as a bit mask

    // address decode and write mask
    always_comb begin
        word_idx = i_wb_adr[cdr_pkg::ADR_W-1:2];
        rel_idx = word_idx - cdr_pkg::STAGE_BASE_IDX;
        dec_stage = rel_idx[6:3];
        in_stage_block = (word_idx >= cdr_pkg::STAGE_BASE_IDX)
            && (rel_idx < cdr_pkg::STAGE_SPAN_IDX)
            && (32'(dec_stage) < NUM_STAGES);
        hit_route = in_stage_block && (rel_idx[2:0] == cdr_pkg::ROUTE_OFS);
        hit_trim = in_stage_block && (rel_idx[2:0] == cdr_pkg::TRIM_OFS);
        hit_status = (word_idx == cdr_pkg::STATUS_IDX);
        req = i_wb_cyc && i_wb_stb && !o_wb_ack;
        wr_mask = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    end

    // ==========================================
    // register writes
    logic [15:0] wr_route;   // merged routing word
    logic [15:0] wr_trim;    // merged trim word

    // next values of the bank; a write lands on the acknowledging edge
    always_comb begin
        wr_route = 16'h0000;
        wr_trim = 16'h0000;
        for (int s = 0; s < NUM_STAGES; s++) begin
            next_route_reg[s] = route_reg[s];
            next_trim_reg[s] = trim_reg[s];
        end
        if (req && i_wb_we) begin
            // only the addressed stage changes
            wr_route = (route_reg[dec_stage] & ~wr_mask) | (i_wb_dat[15:0] & wr_mask);
            wr_trim = (trim_reg[dec_stage] & ~wr_mask) | (i_wb_dat[15:0] & wr_mask);
            // unused trim bits 6 and 14 are never stored
            wr_trim[6] = 1'b0;
            wr_trim[14] = 1'b0;
            for (int s = 0; s < NUM_STAGES; s++) begin
                if (hit_route && 32'(dec_stage) == s) begin
                    next_route_reg[s] = wr_route;
                end
                if (hit_trim && 32'(dec_stage) == s) begin
                    next_trim_reg[s] = wr_trim;
                end
            end
        end
    end

    // bank flops; contents are undefined to software, zero here
    always_ff @(posedge i_clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            for (int s = 0; s < NUM_STAGES; s++) begin
                route_reg[s] <= cdr_pkg::ROUTE_RESET;
                trim_reg[s] <= cdr_pkg::TRIM_RESET;
            end
        end else begin
            for (int s = 0; s < NUM_STAGES; s++) begin
                route_reg[s] <= next_route_reg[s];
                trim_reg[s] <= next_trim_reg[s];
            end
        end
    end

    // ==========================================
    // front-end decode of the active stage
    cdr_pkg::cdr_route_type act_route;        // routing of the active stage
    cdr_pkg::cdr_trim_type act_trim;          // trim of the active stage
    logic stage_valid;                        // sequencer names a real stage
    cdr_pkg::cdr_frontend_type next_frontend;
    cdr_pkg::cdr_status_type next_status;
    cdr_pkg::cdr_status_type status;
    logic [2:0] pos_count;                    // inputs on the positive node
    logic [2:0] neg_count;                    // inputs on the negative node

    // switch matrix, trim gating and single-ended checks
    always_comb begin
        stage_valid = 32'(i_stage) < NUM_STAGES;
        act_route = cdr_pkg::ROUTE_RESET;
        act_trim = cdr_pkg::TRIM_RESET;
        if (stage_valid) begin
            act_route = route_reg[i_stage];
            act_trim = trim_reg[i_stage];
        end
        next_frontend = '0;
        pos_count = 3'h0;
        neg_count = 3'h0;
        for (int i = 0; i < cdr_pkg::ROUTE_INPUTS; i++) begin
            case (act_route.input_route[i])
                cdr_pkg::ROUTE_OPEN: begin
                    // left floating from both nodes
                end
                cdr_pkg::ROUTE_NEG: begin
                    next_frontend.to_neg[i] = 1'b1;
                    neg_count = neg_count + 3'h1;
                end
                cdr_pkg::ROUTE_POS: begin
                    next_frontend.to_pos[i] = 1'b1;
                    pos_count = pos_count + 3'h1;
                end
                cdr_pkg::ROUTE_BIAS: begin
                    next_frontend.to_bias[i] = 1'b1;
                end
                default: begin
                    next_frontend.to_bias[i] = 1'b0;
                end
            endcase
        end
        if (stage_valid) begin
            // mode passed through; 11 means differential
            next_frontend.single_ended_mode_sel = act_route.single_ended_mode_sel;
            // disable bits are active high
            next_frontend.neg_trim_en = !act_route.neg_trim_off;
            next_frontend.pos_trim_en = !act_route.pos_trim_off;
            next_frontend.neg_trim_code = act_trim.neg_trim_code;
            next_frontend.pos_trim_code = act_trim.pos_trim_code;
            next_frontend.neg_trim_to_pos = act_trim.neg_trim_steer;
            next_frontend.pos_trim_to_neg = act_trim.pos_trim_steer;
        end
        next_status = '0;
        next_status.active_stage = i_stage;
        // software is relied on to avoid mode 00; flag it if seen
        next_status.se_forbidden = stage_valid
            && (act_route.single_ended_mode_sel == cdr_pkg::SE_FORBIDDEN);
        // single-ended modes expect exactly one input on the named node
        next_status.se_mismatch = stage_valid
            && (((act_route.single_ended_mode_sel == cdr_pkg::SE_ONE_POS)
                 && (pos_count != 3'h1))
             || ((act_route.single_ended_mode_sel == cdr_pkg::SE_ONE_NEG)
                 && (neg_count != 3'h1)));
    end

    // front-end and status flops
    always_ff @(posedge i_clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            o_frontend <= '0;
            status <= '0;
        end else begin
            o_frontend <= next_frontend;
            status <= next_status;
        end
    end

    // ==========================================
    // bus answer
    logic next_ack;                        // ack for the next cycle
    logic [cdr_pkg::DATA_W-1:0] next_dat;  // read data for the next cycle

    // one ack per request, read data held with it
    always_comb begin
        next_ack = req;
        next_dat = o_wb_dat;
        if (req) begin
            // unmapped words read zero and ignore writes
            next_dat = '0;
            if (!i_wb_we) begin
                if (hit_route) begin
                    next_dat[15:0] = route_reg[dec_stage];
                end else if (hit_trim) begin
                    next_dat[15:0] = trim_reg[dec_stage];
                end else if (hit_status) begin
                    next_dat[15:0] = status;
                end
            end
        end
    end

    // bus flops
    always_ff @(posedge i_clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= '0;
        end else begin
            o_wb_ack <= next_ack;
            o_wb_dat <= next_dat;
        end
    end

endmodule

/* File: core/cdr_pkg.sv */
// constants, field layouts and carriers for the per-stage routing and trim bank
// assumes a single 40 MHz clock domain and a classic Wishbone slave port
//
// Operation
// - one routing and trim copy per stage 0-11
// - six 2-bit routes, inputs 7-12, bits 1:0 upward
// - route 00 leaves input disconnected
// - route 01 joins input to negative node
// - route 10 joins input to positive node
// - route 11 ties input to bias
// - mode 01 when one input on positive
// - mode 10 when one input on negative
// - mode 11 selects differential connection
// - routing bit 14 disables negative trim
// - routing bit 15 disables positive trim
// - trim bits 5:0 negative code, 0.32 pF
// - trim bits 13:8 positive code, same step
// - trim bit 7 steers negative trim
// - trim bit 15 steers positive trim
package cdr_pkg;

    // ==========================================
    // sizes
    localparam int NUM_STAGES = 12;
    localparam int ROUTE_INPUTS = 6;
    localparam int TRIM_W = 6;
    localparam int REG_W = 16;
    localparam int DATA_W = 32;
    localparam int ADR_W = 12;
    localparam int STAGE_W = 4;

    // ==========================================
    // register map, word indices (byte address is four times the index)
    localparam logic [9:0] STAGE_BASE_IDX = 10'h080;
    localparam logic [9:0] STAGE_SPAN_IDX = 10'h060;
    localparam logic [2:0] ROUTE_OFS = 3'h1;
    localparam logic [2:0] TRIM_OFS = 3'h2;
    localparam logic [9:0] STATUS_IDX = 10'h070;
    localparam logic [15:0] ROUTE_RESET = 16'h0000;
    localparam logic [15:0] TRIM_RESET = 16'h0000;

    // ==========================================
    // field encodings
    localparam logic [1:0] ROUTE_OPEN = 2'h0;
    localparam logic [1:0] ROUTE_NEG = 2'h1;
    localparam logic [1:0] ROUTE_POS = 2'h2;
    localparam logic [1:0] ROUTE_BIAS = 2'h3;
    localparam logic [1:0] SE_FORBIDDEN = 2'h0;
    localparam logic [1:0] SE_ONE_POS = 2'h1;
    localparam logic [1:0] SE_ONE_NEG = 2'h2;
    localparam logic [1:0] SE_DIFF = 2'h3;

    // ==========================================
    // register layouts, msb first
    typedef struct packed {
        logic pos_trim_off;                 // bit 15
        logic neg_trim_off;                 // bit 14
        logic [1:0] single_ended_mode_sel;  // bits 13:12
        logic [5:0][1:0] input_route;       // [0] = input7 at bits 1:0
    } cdr_route_type;

    typedef struct packed {
        logic pos_trim_steer;               // bit 15
        logic unused_hi;                    // bit 14, reads zero
        logic [5:0] pos_trim_code;          // bits 13:8
        logic neg_trim_steer;               // bit 7
        logic unused_lo;                    // bit 6, reads zero
        logic [5:0] neg_trim_code;          // bits 5:0
    } cdr_trim_type;

    typedef struct packed {
        logic [9:0] unused;                 // bits 15:6
        logic se_mismatch;                  // bit 5
        logic se_forbidden;                 // bit 4
        logic [3:0] active_stage;           // bits 3:0
    } cdr_status_type;

    // front-end drive for the active stage
    typedef struct packed {
        logic [5:0] to_pos;
        logic [5:0] to_neg;
        logic [5:0] to_bias;
        logic [1:0] single_ended_mode_sel;
        logic neg_trim_en;
        logic neg_trim_to_pos;
        logic [5:0] neg_trim_code;
        logic pos_trim_en;
        logic pos_trim_to_neg;
        logic [5:0] pos_trim_code;
    } cdr_frontend_type;

endpackage

/* File: dv/cdr_stage_regs_assertions.sv */
// port-level checker for the per-stage routing and trim bank
// assumes one clock domain and is bound to every bank instance
`timescale 1ns/1ps

module cdr_stage_regs_checker #(
    parameter int NUM_STAGES = cdr_pkg::NUM_STAGES
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [cdr_pkg::ADR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [cdr_pkg::DATA_W-1:0] i_wb_dat,
    input wire logic [cdr_pkg::DATA_W-1:0] o_wb_dat,
    input wire logic o_wb_ack,
    // sequencer and front end
    input wire logic [cdr_pkg::STAGE_W-1:0] i_stage,
    input wire cdr_pkg::cdr_frontend_type o_frontend
);
    // ==========================================
    // cycles since reset release, saturates at 3, masks the reset synchroniser
    logic [1:0] up_cnt;
    logic [1:0] next_up_cnt;
    always_comb begin
        next_up_cnt = (up_cnt == 2'h3) ? up_cnt : up_cnt + 2'h1;
    end
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            up_cnt <= 2'h0;
        end else begin
            up_cnt <= next_up_cnt;
        end
    end

    default clocking @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);

    // ==========================================
    // bus answer
    ack_one_cycle_a: assert property (
        o_wb_ack |=> !o_wb_ack) else $error("ack held beyond one cycle");
    ack_latency_a: assert property (
        (up_cnt == 2'h3 && i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
        else $error("request not answered next cycle");
    ack_cause_a: assert property (
        $rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb)) else $error("ack without request");
    upper_zero_a: assert property (
        o_wb_ack |-> o_wb_dat[31:16] == 16'h0000) else $error("read data upper half not zero");
    gap_word_a: assert property (
        (i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack && i_wb_adr[11:2] == 10'h080)
        |=> o_wb_dat == 32'h0000_0000) else $error("gap word read not zero");
    // ==========================================
    // front end drive
    no_stage_idle_a: assert property (
        (int'(i_stage) >= NUM_STAGES) |=> o_frontend == '0) else $error("idle stage drives");
    route_onehot_a: assert property (
        ((o_frontend.to_pos & o_frontend.to_neg) | (o_frontend.to_bias
        & (o_frontend.to_pos | o_frontend.to_neg))) == 6'h00) else $error("input on two nodes");
    fe_hold_a: assert property (
        (up_cnt == 2'h3 && $stable(i_stage)
        && !$past(i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack))
        |=> $stable(o_frontend)) else $error("front end moved without cause");
endmodule

bind cdr_stage_regs cdr_stage_regs_checker #(.NUM_STAGES(NUM_STAGES)) u_chk (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_stage(i_stage), .o_frontend(o_frontend));

/* File: dv/cdr_stage_regs_tb.sv */
// self-checking bench for the per-stage routing and trim bank
// assumes the checker file is compiled with it and binds itself
`timescale 1ns/1ps

module cdr_stage_regs_tb;
    // ==========================================
    // drive, observation and shadow copies
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] stage = 4'hF;
    logic [31:0] rd;
    logic [31:0] o_wb_dat;
    logic o_wb_ack;
    cdr_pkg::cdr_frontend_type fe;
    int mismatches = 0;
    int checked = 0;
    logic [15:0] rt [12];
    logic [15:0] tr [12];

    always #12.5 i_clock = ~i_clock;

    cdr_stage_regs dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_wb_cyc(cyc), .i_wb_stb(cyc),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat),
        .o_wb_ack(o_wb_ack), .i_stage(stage), .o_frontend(fe));

    // ==========================================
    // counts, verdict and end of run
    task automatic summarize();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // read data compare
    task automatic chk_dat(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // front-end drive compare
    task automatic chk_fe(input cdr_pkg::cdr_frontend_type got,
        input cdr_pkg::cdr_frontend_type exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one classic cycle, held until ack, bounded wait
    task automatic wb(input logic w, input logic [11:0] a, input logic [15:0] d,
        input logic [3:0] s);
        int n;
        @(posedge i_clock);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        sel <= s;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 20);
        if (o_wb_ack !== 1'b1) begin
            mismatches++;
            summarize();
        end
        rd = o_wb_dat;
        cyc <= 1'b0;
    endtask

    // expected switch and trim drive from the two register words
    function automatic cdr_pkg::cdr_frontend_type exp_fe(input logic [15:0] r,
        input logic [15:0] t);
        cdr_pkg::cdr_frontend_type f;
        f = '0;
        for (int i = 0; i < 6; i++) begin
            f.to_pos[i] = (r[2*i+:2] == 2'h2);
            f.to_neg[i] = (r[2*i+:2] == 2'h1);
            f.to_bias[i] = (r[2*i+:2] == 2'h3);
        end
        f.single_ended_mode_sel = r[13:12];
        f.neg_trim_en = !r[14];
        f.pos_trim_en = !r[15];
        f.neg_trim_code = t[5:0];
        f.neg_trim_to_pos = t[7];
        f.pos_trim_code = t[13:8];
        f.pos_trim_to_neg = t[15];
        return f;
    endfunction

    // ==========================================
    // main sequence
    initial begin
        repeat (3) @(posedge i_clock);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_clock);
        // program every stage first, single-ended mode never 00
        for (int s = 0; s < 12; s++) begin
            rt[s] = {s[1:0], 2'((s % 3) + 1), 12'h0E4 ^ 12'(s * 12'h111)};
            tr[s] = 16'hFFFF ^ 16'(s * 16'h0913);
            wb(1'b1, 12'(32'h204 + 32 * s), rt[s], 4'h3);
            wb(1'b1, 12'(32'h208 + 32 * s), tr[s], 4'h3);
            tr[s] = tr[s] & 16'hBFBF;
        end
        // readback and decode of every stage, all field codes and modes 01, 10 and 11
        for (int s = 0; s < 12; s++) begin
            wb(1'b0, 12'(32'h204 + 32 * s), 16'h0000, 4'hF);
            chk_dat(rd, {16'h0000, rt[s]});
            wb(1'b0, 12'(32'h208 + 32 * s), 16'h0000, 4'hF);
            chk_dat(rd, {16'h0000, tr[s]});
            stage <= 4'(s);
            repeat (2) @(posedge i_clock);
            chk_fe(fe, exp_fe(rt[s], tr[s]));
        end
        // low byte lane only, then no lane at all
        wb(1'b1, 12'h204, 16'h5A5A, 4'h1);
        rt[0][7:0] = 8'h5A;
        wb(1'b1, 12'h204, 16'h0000, 4'h0);
        wb(1'b0, 12'h204, 16'h0000, 4'hF);
        chk_dat(rd, {16'h0000, rt[0]});
        // gap word in a stage block: acked, write dropped, reads zero
        wb(1'b1, 12'h200, 16'hFFFF, 4'h3);
        wb(1'b0, 12'h200, 16'h0000, 4'hF);
        chk_dat(rd, 32'h0000_0000);
        // status flags of stage 0 for forbidden and mismatched single-ended modes
        stage <= 4'h0;
        wb(1'b1, 12'h204, 16'h0000, 4'h3);
        wb(1'b0, 12'h1C0, 16'h0000, 4'hF);
        chk_dat(rd, 32'h0000_0010);
        wb(1'b1, 12'h204, 16'h1000, 4'h3);
        wb(1'b0, 12'h1C0, 16'h0000, 4'hF);
        chk_dat(rd, 32'h0000_0020);
        wb(1'b1, 12'h204, 16'h1002, 4'h3);
        wb(1'b0, 12'h1C0, 16'h0000, 4'hF);
        chk_dat(rd, 32'h0000_0000);
        wb(1'b1, 12'h204, 16'h2000, 4'h3);
        wb(1'b0, 12'h1C0, 16'h0000, 4'hF);
        chk_dat(rd, 32'h0000_0020);
        wb(1'b1, 12'h204, 16'h2001, 4'h3);
        wb(1'b0, 12'h1C0, 16'h0000, 4'hF);
        chk_dat(rd, 32'h0000_0000);
        // stage numbers past the bank drive nothing
        stage <= 4'hC;
        repeat (2) @(posedge i_clock);
        chk_fe(fe, '0);
        summarize();
    end
endmodule
